// file: core/tmr_unit.sv
`timescale 1ns/1ps

// How it works
// - Mode 00 prescaled 8-bit, 01 full 16-bit.
// - Mode 10 low byte reloads from high byte.
// - Mode 11 splits bytes; high uses timer1 bits.
// - Timer2 count is two software-accessible bytes.
// - Timer2 advances only while its run bit set.
// - Timer mode increments every two clocks.
// - Counter mode increments on count pin falls.
// - Reload mode reloads on overflow or trigger.
// - Capture mode copies count on trigger fall.
// - Baud use forces reload, ignores capture select.
// - Trigger fall sets external flag when enabled, outside baud use; software clears.
// - Selects pick timer1 or timer2 serial clocks.
// - Reload pair is read-write, resets to zero.
module tmr_unit import tmr_pkg::*; (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       timer0_run_bit,
	input  wire logic       timer1_run_bit,
	input  wire logic       timer1_overflow_in,
	input  wire logic       timer2_count_pin,
	input  wire logic       external_trigger_pin,
	output logic            timer0_overflow,
	output logic            timer1_overflow_flag,
	output logic            uart_rx_clock,
	output logic            uart_tx_clock,
	output logic            timer2_overflow_flag,
	output logic            timer2_external_flag
);

	// ----------------------------------------------------------------------
	// State
	// ----------------------------------------------------------------------
	logic [7:0]  mode_reg,  mode_next;
	logic [7:0]  tl0_reg,   tl0_next;
	logic [7:0]  th0_reg,   th0_next;
	logic [7:0]  tl1_reg,   tl1_next;
	logic [7:0]  th1_reg,   th1_next;
	logic [7:0]  t2ctl_reg, t2ctl_next;
	logic [15:0] rcap_reg,  rcap_next;
	logic [15:0] cnt2_reg,  cnt2_next;
	logic [7:0]  rdata_reg, rdata_next;
	logic        t0ovf_reg, t0ovf_next;
	logic        t1ovf_reg, t1ovf_next;
	logic        rxck_reg,  rxck_next;
	logic        txck_reg,  txck_next;

	logic        tick;
	logic        cnt_fall;
	logic        ext_fall;
	logic        wr;
	logic [1:0]  t0_mode;
	logic        baud;
	logic        t2_inc;
	logic        t2_ext;
	logic        t2_ovf;
	logic        t2_capture;

	tmr_tick u_tick (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.tick (tick)
	);

	// Both pins are asynchronous and pass two flip-flops inside the detector.
	tmr_fall_det u_cnt_pin (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.pin  (timer2_count_pin),
		.fall (cnt_fall)
	);

	tmr_fall_det u_ext_pin (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.pin  (external_trigger_pin),
		.fall (ext_fall)
	);

	assign wr         = sfr_wr & ce;
	assign t0_mode    = mode_reg[TMR_T0_MODE_LSB +: 2];
	assign baud       = t2ctl_reg[TMR_T2_RXCLK_BIT] | t2ctl_reg[TMR_T2_TXCLK_BIT];
	assign t2_capture = t2ctl_reg[TMR_T2_CAPSEL_BIT] & ~baud;

	// ----------------------------------------------------------------------
	// Timer0 with the split mode borrowing timer1 controls.
	// ----------------------------------------------------------------------
	always_comb begin
		mode_next  = mode_reg;
		tl0_next   = tl0_reg;
		th0_next   = th0_reg;
		tl1_next   = tl1_reg;
		th1_next   = th1_reg;
		t0ovf_next = 1'b0;
		t1ovf_next = 1'b0;
		// Every mode shares one tick, so timer0 advances at half the clock rate.
		if (tick) begin
			case (t0_mode)
				TMR_T0_M13: begin
					if (timer0_run_bit) begin
						if (tl0_reg[4:0] == 5'h1f) begin
							tl0_next = {tl0_reg[7:5], 5'h00};
							th0_next = th0_reg + 8'h01;
							t0ovf_next = (th0_reg == 8'hff);
						end else begin
							tl0_next = {tl0_reg[7:5], tl0_reg[4:0] + 5'h01};
						end
					end
				end
				TMR_T0_M16: begin
					if (timer0_run_bit) begin
						{th0_next, tl0_next} = {th0_reg, tl0_reg} + 16'h0001;
						t0ovf_next = ({th0_reg, tl0_reg} == 16'hffff);
					end
				end
				TMR_T0_M8AR: begin
					if (timer0_run_bit) begin
						if (tl0_reg == 8'hff) begin
							tl0_next   = th0_reg;
							t0ovf_next = 1'b1;
						end else begin
							tl0_next = tl0_reg + 8'h01;
						end
					end
				end
				default: begin
					if (timer0_run_bit) begin
						tl0_next   = tl0_reg + 8'h01;
						t0ovf_next = (tl0_reg == 8'hff);
					end
					if (timer1_run_bit) begin
						th0_next   = th0_reg + 8'h01;
						t1ovf_next = (th0_reg == 8'hff);
					end
				end
			endcase
		end
		// A software write wins over a count in the same cycle.
		if (wr) begin
			if (sfr_addr == TMR_ADDR_MODE) begin
				mode_next = sfr_wdata;
			end else if (sfr_addr == TMR_ADDR_T0_LOW) begin
				tl0_next = sfr_wdata;
			end else if (sfr_addr == TMR_ADDR_T0_HIGH) begin
				th0_next = sfr_wdata;
			end else if (sfr_addr == TMR_ADDR_T1_LOW) begin
				tl1_next = sfr_wdata;
			end else if (sfr_addr == TMR_ADDR_T1_HIGH) begin
				th1_next = sfr_wdata;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			mode_reg  <= TMR_RST_BYTE;
			tl0_reg   <= TMR_RST_BYTE;
			th0_reg   <= TMR_RST_BYTE;
			tl1_reg   <= TMR_RST_BYTE;
			th1_reg   <= TMR_RST_BYTE;
			t0ovf_reg <= 1'b0;
			t1ovf_reg <= 1'b0;
		end else if (ce) begin
			mode_reg  <= mode_next;
			tl0_reg   <= tl0_next;
			th0_reg   <= th0_next;
			tl1_reg   <= tl1_next;
			th1_reg   <= th1_next;
			t0ovf_reg <= t0ovf_next;
			t1ovf_reg <= t1ovf_next;
		end
	end

	// ----------------------------------------------------------------------
	// Timer2 count, reload, capture and flags.
	// ----------------------------------------------------------------------
	always_comb begin
		t2_inc = t2ctl_reg[TMR_T2_RUN_BIT] &
			(t2ctl_reg[TMR_T2_CNTSEL_BIT] ? cnt_fall : tick);
		t2_ext = ext_fall & t2ctl_reg[TMR_T2_EXEN_BIT] & ~baud;
		t2_ovf = t2_inc & (cnt2_reg == 16'hffff);
		cnt2_next  = cnt2_reg;
		rcap_next  = rcap_reg;
		t2ctl_next = t2ctl_reg;
		if (t2_inc) begin
			if (t2_ovf) begin
				cnt2_next = t2_capture ? 16'h0000 : rcap_reg;
			end else begin
				cnt2_next = cnt2_reg + 16'h0001;
			end
		end
		// The trigger is applied after the overflow, so its reload wins a tie.
		if (t2_ext) begin
			if (t2_capture) begin
				rcap_next = cnt2_reg;
			end else begin
				cnt2_next = rcap_reg;
			end
		end
		if (wr) begin
			if (sfr_addr == TMR_ADDR_T2_CTRL) begin
				t2ctl_next = sfr_wdata;
			end else if (sfr_addr == TMR_ADDR_T2_RC_LOW) begin
				rcap_next[7:0] = sfr_wdata;
			end else if (sfr_addr == TMR_ADDR_T2_RC_HI) begin
				rcap_next[15:8] = sfr_wdata;
			end else if (sfr_addr == TMR_ADDR_T2_LOW) begin
				cnt2_next[7:0] = sfr_wdata;
			end else if (sfr_addr == TMR_ADDR_T2_HIGH) begin
				cnt2_next[15:8] = sfr_wdata;
			end
		end
		// Setting wins so an event coinciding with a software clear is kept.
		if (t2_ovf & ~baud) begin
			t2ctl_next[TMR_T2_OVF_BIT] = 1'b1;
		end
		if (t2_ext) begin
			t2ctl_next[TMR_T2_EXT_BIT] = 1'b1;
		end
		// Baud pulses are registered so the serial side sees a clean strobe.
		rxck_next = t2ctl_reg[TMR_T2_RXCLK_BIT] ? t2_ovf : timer1_overflow_in;
		txck_next = t2ctl_reg[TMR_T2_TXCLK_BIT] ? t2_ovf : timer1_overflow_in;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			t2ctl_reg <= TMR_RST_BYTE;
			rcap_reg  <= TMR_RST_WORD;
			cnt2_reg  <= TMR_RST_WORD;
			rxck_reg  <= 1'b0;
			txck_reg  <= 1'b0;
		end else if (ce) begin
			t2ctl_reg <= t2ctl_next;
			rcap_reg  <= rcap_next;
			cnt2_reg  <= cnt2_next;
			rxck_reg  <= rxck_next;
			txck_reg  <= txck_next;
		end
	end

	// ----------------------------------------------------------------------
	// Read port, registered; unmapped addresses read zero.
	// ----------------------------------------------------------------------
	always_comb begin
		// The strobe is not gated here; the register below holds while frozen.
		rdata_next = rdata_reg;
		if (sfr_rd) begin
			if (sfr_addr == TMR_ADDR_MODE) begin
				rdata_next = mode_reg;
			end else if (sfr_addr == TMR_ADDR_T0_LOW) begin
				rdata_next = tl0_reg;
			end else if (sfr_addr == TMR_ADDR_T1_LOW) begin
				rdata_next = tl1_reg;
			end else if (sfr_addr == TMR_ADDR_T0_HIGH) begin
				rdata_next = th0_reg;
			end else if (sfr_addr == TMR_ADDR_T1_HIGH) begin
				rdata_next = th1_reg;
			end else if (sfr_addr == TMR_ADDR_T2_CTRL) begin
				rdata_next = t2ctl_reg;
			end else if (sfr_addr == TMR_ADDR_T2_RC_LOW) begin
				rdata_next = rcap_reg[7:0];
			end else if (sfr_addr == TMR_ADDR_T2_RC_HI) begin
				rdata_next = rcap_reg[15:8];
			end else if (sfr_addr == TMR_ADDR_T2_LOW) begin
				rdata_next = cnt2_reg[7:0];
			end else if (sfr_addr == TMR_ADDR_T2_HIGH) begin
				rdata_next = cnt2_reg[15:8];
			end else begin
				rdata_next = 8'h00;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata_reg <= TMR_RST_BYTE;
		end else if (ce) begin
			rdata_reg <= rdata_next;
		end
	end

	// ----------------------------------------------------------------------
	// Outputs, all taken straight from registers.
	// ----------------------------------------------------------------------
	assign sfr_rdata            = rdata_reg;
	assign timer0_overflow      = t0ovf_reg;
	assign timer1_overflow_flag = t1ovf_reg;
	assign uart_rx_clock        = rxck_reg;
	assign uart_tx_clock        = txck_reg;
	assign timer2_overflow_flag = t2ctl_reg[TMR_T2_OVF_BIT];
	assign timer2_external_flag = t2ctl_reg[TMR_T2_EXT_BIT];

endmodule

// file: core/tmr_pkg.sv
package tmr_pkg;

	// ----------------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------------
	localparam logic [7:0] TMR_ADDR_MODE      = 8'h89;
	localparam logic [7:0] TMR_ADDR_T0_LOW    = 8'h8a;
	localparam logic [7:0] TMR_ADDR_T1_LOW    = 8'h8b;
	localparam logic [7:0] TMR_ADDR_T0_HIGH   = 8'h8c;
	localparam logic [7:0] TMR_ADDR_T1_HIGH   = 8'h8d;
	localparam logic [7:0] TMR_ADDR_T2_CTRL   = 8'hc8;
	localparam logic [7:0] TMR_ADDR_T2_RC_LOW = 8'hca;
	localparam logic [7:0] TMR_ADDR_T2_RC_HI  = 8'hcb;
	localparam logic [7:0] TMR_ADDR_T2_LOW    = 8'hcc;
	localparam logic [7:0] TMR_ADDR_T2_HIGH   = 8'hcd;

	// ----------------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------------
	localparam int TMR_T0_MODE_LSB   = 0;
	localparam int TMR_T2_OVF_BIT    = 7;
	localparam int TMR_T2_EXT_BIT    = 6;
	localparam int TMR_T2_RXCLK_BIT  = 5;
	localparam int TMR_T2_TXCLK_BIT  = 4;
	localparam int TMR_T2_EXEN_BIT   = 3;
	localparam int TMR_T2_RUN_BIT    = 2;
	localparam int TMR_T2_CNTSEL_BIT = 1;
	localparam int TMR_T2_CAPSEL_BIT = 0;

	// ----------------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------------
	localparam logic [7:0]  TMR_RST_BYTE = 8'h00;
	localparam logic [15:0] TMR_RST_WORD = 16'h0000;
	localparam logic [1:0]  TMR_T0_M13   = 2'b00;
	localparam logic [1:0]  TMR_T0_M16   = 2'b01;
	localparam logic [1:0]  TMR_T0_M8AR  = 2'b10;
	localparam logic [1:0]  TMR_T0_MSPL  = 2'b11;

	// ----------------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------------
	localparam int TMR_TICK_CYCLES = 2;

endpackage

// file: core/tmr_fall_det.sv
`timescale 1ns/1ps

module tmr_fall_det (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	input  wire logic pin,
	output logic      fall
);

	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;

	// ----------------------------------------------------------------------
	// Two-stage synchroniser, then a falling edge on the settled copy.
	// ----------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			prev_reg  <= 1'b1;
		end else if (ce) begin
			sync1_reg <= pin;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	assign fall = ce & prev_reg & ~sync2_reg;

endmodule

// file: core/tmr_tick.sv
`timescale 1ns/1ps

module tmr_tick import tmr_pkg::*; (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic ce,
	output logic      tick
);

	logic [1:0] cnt_reg;
	logic [1:0] cnt_next;

	// ----------------------------------------------------------------------
	// One tick every TMR_TICK_CYCLES enabled clocks.
	// ----------------------------------------------------------------------
	always_comb begin
		if (cnt_reg == 2'(TMR_TICK_CYCLES - 1)) begin
			cnt_next = 2'h0;
		end else begin
			cnt_next = cnt_reg + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cnt_reg <= 2'h0;
		end else if (ce) begin
			cnt_reg <= cnt_next;
		end
	end

	assign tick = ce & (cnt_reg == 2'(TMR_TICK_CYCLES - 1));

endmodule

// file: verification/tmr_unit_asserts.sv
`timescale 1ns/1ps

module tmr_chk (
	input logic       clk,
	input logic       rstn,
	input logic       ce,
	input logic [7:0] sfr_addr,
	input logic       sfr_wr,
	input logic [7:0] sfr_wdata,
	input logic       timer1_run_bit,
	input logic       timer1_overflow_in,
	input logic       timer1_overflow_flag,
	input logic       uart_rx_clock,
	input logic       uart_tx_clock,
	input logic       timer2_overflow_flag,
	input logic       timer2_external_flag
);
	// ----------------------------------------
	// Shadow of the fields only software writes.
	// ----------------------------------------
	logic [7:0] ctl_reg;
	logic [7:0] ctl_next;
	logic [1:0] mode_reg;
	logic [1:0] mode_next;
	logic       wc;
	logic       wm;
	assign wc = ce && sfr_wr && sfr_addr == 8'hc8;
	assign wm = ce && sfr_wr && sfr_addr == 8'h89;
	always_comb begin
		ctl_next = wc ? sfr_wdata : ctl_reg;
		mode_next = wm ? sfr_wdata[1:0] : mode_reg;
	end
	always_ff @(posedge clk) begin
		ctl_reg <= rstn ? ctl_next : 8'h00;
		mode_reg <= rstn ? mode_next : 2'b00;
	end
	// ----------------------------------------
	// Properties.
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Four cycles of margin cover the pulse pipeline behind the selects.
	sequence s_rx_stop; ctl_reg[5] && !ctl_reg[2]; endsequence
	sequence s_t1_off; mode_reg != 2'b11 || !timer1_run_bit; endsequence
	property p_ovf_hold; timer2_overflow_flag && !wc |=> timer2_overflow_flag; endproperty
	property p_ext_hold; timer2_external_flag && !wc |=> timer2_external_flag; endproperty
	property p_rx_t1; ce && !ctl_reg[5] |=> uart_rx_clock == $past(timer1_overflow_in);
	endproperty
	property p_tx_t1; ce && !ctl_reg[4] |=> uart_tx_clock == $past(timer1_overflow_in);
	endproperty
	property p_baud_flag;
		(ctl_reg[5] || ctl_reg[4]) && !timer2_overflow_flag && !wc |=> !timer2_overflow_flag;
	endproperty
	property p_ext_off;
		(ctl_reg[5] || ctl_reg[4] || !ctl_reg[3]) && !timer2_external_flag && !wc
			|=> !timer2_external_flag;
	endproperty
	property p_stop; s_rx_stop [*4] |-> !uart_rx_clock; endproperty
	property p_t1_off; s_t1_off [*4] |-> !timer1_overflow_flag; endproperty
	a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag dropped");
	a_ext_hold: assert property (p_ext_hold) else $error("external flag dropped");
	a_rx_t1: assert property (p_rx_t1) else $error("rx clock not timer1");
	a_tx_t1: assert property (p_tx_t1) else $error("tx clock not timer1");
	a_baud_flag: assert property (p_baud_flag) else $error("flag set in baud use");
	a_ext_off: assert property (p_ext_off) else $error("trigger not refused");
	a_stop: assert property (p_stop) else $error("stopped timer overflowed");
	a_t1_off: assert property (p_t1_off) else $error("split high byte ran");
endmodule

bind tmr_unit tmr_chk i_chk (
	.clk                  (clk),
	.rstn                 (rstn),
	.ce                   (ce),
	.sfr_addr             (sfr_addr),
	.sfr_wr               (sfr_wr),
	.sfr_wdata            (sfr_wdata),
	.timer1_run_bit       (timer1_run_bit),
	.timer1_overflow_in   (timer1_overflow_in),
	.timer1_overflow_flag (timer1_overflow_flag),
	.uart_rx_clock        (uart_rx_clock),
	.uart_tx_clock        (uart_tx_clock),
	.timer2_overflow_flag (timer2_overflow_flag),
	.timer2_external_flag (timer2_external_flag)
);

// file: verification/tmr_unit_tb.sv
`timescale 1ns/1ps

module tmr_unit_tb;
	import tmr_pkg::*;
	// ----------------------------------------
	// Signals and helpers.
	// ----------------------------------------
	logic       clk, rstn, ce, sfr_wr, sfr_rd, timer0_run_bit, timer1_run_bit;
	logic       timer1_overflow_in, timer2_count_pin, external_trigger_pin;
	logic       timer0_overflow, timer1_overflow_flag, uart_rx_clock, uart_tx_clock;
	logic       timer2_overflow_flag, timer2_external_flag;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd;
	int         failures, comparisons, n;
	tmr_unit i_dut (
		.clk                  (clk),
		.rstn                 (rstn),
		.ce                   (ce),
		.sfr_addr             (sfr_addr),
		.sfr_wr               (sfr_wr),
		.sfr_rd               (sfr_rd),
		.sfr_wdata            (sfr_wdata),
		.sfr_rdata            (sfr_rdata),
		.timer0_run_bit       (timer0_run_bit),
		.timer1_run_bit       (timer1_run_bit),
		.timer1_overflow_in   (timer1_overflow_in),
		.timer2_count_pin     (timer2_count_pin),
		.external_trigger_pin (external_trigger_pin),
		.timer0_overflow      (timer0_overflow),
		.timer1_overflow_flag (timer1_overflow_flag),
		.uart_rx_clock        (uart_rx_clock),
		.uart_tx_clock        (uart_tx_clock),
		.timer2_overflow_flag (timer2_overflow_flag),
		.timer2_external_flag (timer2_external_flag)
	);
	always #2 clk = ~clk;
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask
	// A gap cycle after each strobe keeps two writes from sharing a time step.
	task automatic wreg(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		sfr_wr = 1;
		sfr_addr = a;
		sfr_wdata = d;
		@(negedge clk);
		sfr_wr = 0;
	endtask
	task automatic rchk(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
		@(negedge clk);
		sfr_rd = 1;
		sfr_addr = a;
		@(negedge clk);
		sfr_rd = 0;
		rd = sfr_rdata;
		chk($sformatf("reg %h", a), e, rd & m);
	endtask
	task automatic pulse(ref logic p);
		p = 0;
		repeat (4) @(negedge clk);
		p = 1;
		repeat (4) @(negedge clk);
	endtask
	// Selector 0 waits for the timer2 flag, 1 for timer0 and 2 for the split high byte.
	task automatic wait_for(int sel, int lim);
		logic s;
		n = 0;
		s = 1'b0;
		while (s !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
			s = (sel == 0) ? timer2_overflow_flag :
				(sel == 1) ? timer0_overflow : timer1_overflow_flag;
		end
		chk("wait", 8'h01, 8'(n < lim));
	endtask
	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_regs;
		logic [7:0] a[9] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd};
		foreach (a[i]) rchk(a[i], 8'h00);
		rchk(8'h00, 8'h00);
		foreach (a[i]) if (i != 4) wreg(a[i], {4'h5, 4'(i)});
		foreach (a[i]) if (i != 4) rchk(a[i], {4'h5, 4'(i)});
		@(negedge clk);
		timer1_overflow_in = 1;
		@(negedge clk);
		timer1_overflow_in = 0;
		chk("uart clocks", 8'h03, {6'h00, uart_rx_clock, uart_tx_clock});
		$display("registers done");
	endtask
	task automatic t_rate;
		wreg(8'hca, 8'h00);
		wreg(8'hcb, 8'h12);
		wreg(8'hcc, 8'hf0);
		wreg(8'hcd, 8'hff);
		wreg(8'hc8, 8'h04);
		wait_for(0, 200);
		chk("rate", 8'h01, 8'(n > 29 && n < 35));
		wreg(8'hc8, 8'h80);
		rchk(8'hcd, 8'h12);
		rchk(8'hcc, 8'h00, 8'h00);
		repeat (10) @(negedge clk);
		rchk(8'hcc, rd);
		rchk(8'hc8, 8'h80);
		wreg(8'hc8, 8'h00);
		rchk(8'hc8, 8'h00);
		wreg(8'hcc, 8'h00);
		wreg(8'hc8, 8'h06);
		repeat (5) pulse(timer2_count_pin);
		wreg(8'hc8, 8'h00);
		rchk(8'hcc, 8'h05);
		$display("timer2 count done");
	endtask
	task automatic t_trig;
		wreg(8'hcd, 8'h56);
		wreg(8'hc8, 8'h0d);
		pulse(external_trigger_pin);
		rchk(8'hc8, 8'h4d);
		wreg(8'hc8, 8'h00);
		rchk(8'hcb, 8'h56);
		wreg(8'hcb, 8'hab);
		wreg(8'hc8, 8'h0c);
		pulse(external_trigger_pin);
		rchk(8'hc8, 8'h4c);
		wreg(8'hc8, 8'h00);
		rchk(8'hcd, 8'hab);
		wreg(8'hc8, 8'h04);
		pulse(external_trigger_pin);
		rchk(8'hc8, 8'h04);
		$display("trigger done");
	endtask
	task automatic t_baud;
		wreg(8'hca, 8'h00);
		wreg(8'hcb, 8'h77);
		wreg(8'hcc, 8'hf0);
		wreg(8'hcd, 8'hff);
		wreg(8'hc8, 8'h3d);
		n = 0;
		repeat (40) begin
			@(negedge clk);
			n += int'({uart_tx_clock, uart_rx_clock});
		end
		pulse(external_trigger_pin);
		chk("baud pulses", 8'h03, 8'(n));
		rchk(8'hc8, 8'h3d);
		wreg(8'hc8, 8'h30);
		rchk(8'hcd, 8'h77);
		rchk(8'hca, 8'h00);
		repeat (6) @(negedge clk);
		wreg(8'hc8, 8'h00);
		$display("baud done");
	endtask
	task automatic t_t0;
		for (int m = 0; m < 2; m++) begin
			wreg(8'h89, 8'(m));
			wreg(8'h8a, m ? 8'hff : 8'h1f);
			wreg(8'h8c, 8'h00);
			timer0_run_bit = 1;
			repeat (5) @(negedge clk);
			timer0_run_bit = 0;
			rchk(8'h8c, 8'h01);
		end
		wreg(8'h89, 8'h02);
		wreg(8'h8c, 8'h80);
		wreg(8'h8a, 8'hfe);
		timer0_run_bit = 1;
		wait_for(1, 20);
		timer0_run_bit = 0;
		rchk(8'h8a, 8'h80, 8'hf0);
		wreg(8'h89, 8'h03);
		wreg(8'h8a, 8'hfe);
		timer0_run_bit = 1;
		wait_for(1, 20);
		timer0_run_bit = 0;
		rchk(8'h8c, 8'h80);
		wreg(8'h8c, 8'hfe);
		timer1_run_bit = 1;
		wait_for(2, 20);
		timer1_run_bit = 0;
		$display("timer0 done");
	endtask
	// Twenty frozen cycles leave two enabled edges, so exactly one tick lands.
	task automatic t_freeze;
		wreg(8'hcc, 8'h00);
		wreg(8'hc8, 8'h04);
		ce = 0;
		repeat (20) @(negedge clk);
		ce = 1;
		wreg(8'hc8, 8'h00);
		rchk(8'hcc, 8'h01);
		$display("clock enable done");
	endtask
	// ----------------------------------------
	// Main sequence and watchdog.
	// ----------------------------------------
	initial begin
		{clk, rstn, sfr_wr, sfr_rd, timer0_run_bit, timer1_run_bit} = 6'h00;
		{ce, timer1_overflow_in, timer2_count_pin, external_trigger_pin} = 4'hb;
		{sfr_addr, sfr_wdata, failures, comparisons} = '0;
		repeat (6) @(negedge clk);
		rstn = 1;
		t_regs;
		t_rate;
		t_trig;
		t_baud;
		t_t0;
		t_freeze;
		end_of_test;
	end
	initial begin
		#20000;
		failures++;
		end_of_test;
	end
endmodule
